// *** design/htec_defs.vh ***
// Summary of operation
// R01: continuous mode: armed block accepts repeated triggers
// R02: trigger source waits for trigger ready high
// R03: rising edge starts timed exposure, exact length
// R04: exposure end starts readout then transmission
// R05: after stop, trigger edges are ignored
// R06: source must not exceed maximum frame rate
// R07: rate limit below maximum caps trigger rate
// R08: rate limit above maximum uses maximum rate
// R09: exposure time clamped to model minimum
// R10: exposure time clamped to model maximum
// R11: exposure set by raw count or absolute
// R12: auto exposure keeps own unquantised absolute value
// R13: auto exposure disabled in trigger width mode
// R14: exposure equals raw count times time base
// R15: trigger width mode exposes while trigger active
// R16: unreachable absolute value rounds to nearest raw
// R17: trigger ready low whenever trigger not accepted; code keeps ready high in the first acq_stop clock, where edges drop
`ifndef HTEC_DEFS_VH
`define HTEC_DEFS_VH
// ==========================================================
// timing
`define HTEC_CLK_MHZ      7'd100
`define HTEC_US_CYC       7'd100
`define HTEC_US_W         24
`define HTEC_RAW_MIN      12'h001
`define HTEC_RAW_MAX      12'hfff
`define HTEC_EXP_MIN_US   24'h000018
`define HTEC_EXP_MAX_US   24'h0f4240
`define HTEC_EXP_RST_US   24'h013fec
`define HTEC_PER_SAT      32'hffffffff
`define HTEC_TB_RST_US    24'h000014
`define HTEC_AUTO_RST_US  24'h0003e8
`endif

// *** design/htec_div.v ***
`timescale 1ns/1ps
// ==========================================================
// nearest-integer divide by iterative restoring division
module htec_div (
  // clock and reset
  input  wire        mclk,
  input  wire        sys_rst,
  // request
  input  wire        start,
  input  wire [23:0] num,
  input  wire [23:0] den,
  // answer
  output reg         done,
  output reg  [23:0] quot
);
  reg [23:0] q_r;
  reg [24:0] rem_r;
  reg [23:0] n_r;
  reg [4:0]  cnt_r;
  reg        busy_r;
  wire [24:0] trial = {rem_r[23:0], n_r[23]};
  wire [24:0] dsub  = trial - {1'b0, den};

  // one quotient bit per clock, 24 clocks, then round half up
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q_r <= 24'h000000; rem_r <= 25'h0000000; n_r <= 24'h000000;
      cnt_r <= 5'h00; busy_r <= 1'b0; done <= 1'b0; quot <= 24'h000000;
    end else begin
      done <= 1'b0;
      if (start && !busy_r) begin
        busy_r <= 1'b1; n_r <= num; rem_r <= 25'h0000000;
        q_r <= 24'h000000; cnt_r <= 5'h18;
      end else if (busy_r) begin
        if (cnt_r != 5'h00) begin
          n_r <= {n_r[22:0], 1'b0};
          cnt_r <= cnt_r - 5'h01;
          if (!dsub[24]) begin
            rem_r <= dsub; q_r <= {q_r[22:0], 1'b1};
          end else begin
            rem_r <= trial; q_r <= {q_r[22:0], 1'b0};
          end
        end else begin
          busy_r <= 1'b0; done <= 1'b1;
          // nearest value: round up when remainder >= half divisor
          quot <= ({rem_r[23:0], 1'b0} >= {1'b0, den}) ?
                  q_r + 24'h000001 : q_r; // R16
        end
      end
    end
  end
endmodule

// *** design/htec_ctrl.v ***
`timescale 1ns/1ps
`include "htec_defs.vh"
// ==========================================================
// hardware trigger exposure control, continuous mode
module htec_ctrl (
  // clock and reset
  input  wire        mclk,
  input  wire        sys_rst,
  // commands and configuration
  input  wire        acq_start,
  input  wire        acq_stop,
  input  wire        edge_falling,
  input  wire        width_mode,
  input  wire        raw_wr,
  input  wire [11:0] raw_val,
  input  wire        abs_wr,
  input  wire [23:0] abs_us,
  input  wire        base_wr,
  input  wire [23:0] base_us,
  input  wire        auto_en,
  input  wire        auto_wr,
  input  wire [23:0] auto_us,
  input  wire        rate_en,
  input  wire [31:0] rate_period_cyc,
  input  wire [31:0] min_period_cyc,
  input  wire        readout_done,
  // link pins
  input  wire        external_trigger_input,
  output reg         trigger_ready_output,
  // status
  output reg         armed,
  output reg         exposing,
  output reg         readout_start,
  output reg  [11:0] raw_out,
  output reg  [23:0] exp_abs_out,
  output reg  [23:0] auto_abs_out,
  output reg         auto_active
);
  // ========================================================
  // one-hot states: waiting for an edge, exposing, and waiting for
  // the readout side to finish before the next edge may be taken
  localparam S_IDLE = 3'b001;
  localparam S_EXP  = 3'b010;
  localparam S_RD   = 3'b100;

  reg [2:0]  state_r;
  reg        trig_d_r;
  reg [23:0] base_r;
  reg [23:0] us_left_r;
  reg [6:0]  sub_r;
  reg [31:0] per_cnt_r;
  reg        div_go_r;
  wire       div_done;
  wire [23:0] div_q;
  // saturating count of clocks since the last accepted trigger
  wire [31:0] per_cnt_nxt;

  // clamp exposure in microseconds to the model limits
  // a limit is applied, not refused, so a host write never fails
  function [23:0] clamp_us;
    input [23:0] v;
    begin
      if (v < `HTEC_EXP_MIN_US) clamp_us = `HTEC_EXP_MIN_US; // R09
      else if (v > `HTEC_EXP_MAX_US) clamp_us = `HTEC_EXP_MAX_US; // R10
      else clamp_us = v;
    end
  endfunction

  // clamp raw count to its legal range
  function [11:0] clamp_raw;
    input [23:0] v;
    begin
      if (v < {12'h000, `HTEC_RAW_MIN}) clamp_raw = `HTEC_RAW_MIN;
      else if (v > {12'h000, `HTEC_RAW_MAX}) clamp_raw = `HTEC_RAW_MAX;
      else clamp_raw = v[11:0];
    end
  endfunction

  // product of raw and base, saturated and clamped
  function [23:0] raw_to_us;
    input [11:0] r;
    input [23:0] b;
    reg   [35:0] p;
    begin
      p = r * b; // R14
      raw_to_us = clamp_us((p[35:24] != 12'h000) ? 24'hffffff : p[23:0]);
    end
  endfunction

  // gate test on the clocks counted since the last accepted edge; the
  // saturated count stands for no edge taken since reset
  function period_met;
    input [31:0] cnt;
    input [31:0] per;
    begin
      period_met = (cnt == `HTEC_PER_SAT) || (cnt >= per); // R07 R08
    end
  endfunction

  // absolute value to raw count, rounded to the nearest step; the
  // result lands some 27 clocks after the write
  htec_div u_div (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .start   (div_go_r),
    .num     (clamp_us(abs_us)),
    .den     (base_r),
    .done    (div_done),
    .quot    (div_q)
  );

  // fold the activation polarity in so one detector serves both
  wire trig_act  = external_trigger_input ^ edge_falling;
  wire trig_edge = trig_act & ~trig_d_r; // R03
  // the period the trigger may repeat at: the slower of limit and max
  wire [31:0] eff_period = (rate_en && rate_period_cyc > min_period_cyc) ?
                           rate_period_cyc : min_period_cyc; // R07 R08
  wire rate_ok = period_met(per_cnt_r, eff_period);
  // ready looks one clock ahead so it opens in the cycle the gate does;
  // a plain +1 would wrap the saturated count to zero and stay shut
  assign per_cnt_nxt = (per_cnt_r == `HTEC_PER_SAT) ? `HTEC_PER_SAT :
                       per_cnt_r + 32'h00000001;
  // length loaded at an edge: the auto value while auto is active, else the set exposure
  wire [23:0] exp_used = (auto_active) ? auto_abs_out : exp_abs_out;

  // ========================================================
  // exposure settings: raw, absolute, time base, auto value
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      base_r <= `HTEC_TB_RST_US;
      raw_out <= `HTEC_RAW_MAX;
      // reset exposure agrees with reset raw count times reset base
      exp_abs_out <= `HTEC_EXP_RST_US; // R14
      auto_abs_out <= `HTEC_AUTO_RST_US;
      auto_active <= 1'b0;
      div_go_r <= 1'b0;
    end else begin
      // divider reads abs_us a clock after the write; it must still stand
      div_go_r <= abs_wr; // R11
      auto_active <= auto_en & ~width_mode; // R13
      if (base_wr && base_us != 24'h000000) begin
        base_r <= base_us;
        exp_abs_out <= raw_to_us(raw_out, base_us);
      end else if (raw_wr) begin
        raw_out <= clamp_raw({12'h000, raw_val}); // R11
        exp_abs_out <= raw_to_us(clamp_raw({12'h000, raw_val}), base_r);
      end else if (div_done) begin
        raw_out <= clamp_raw(div_q); // R16
        exp_abs_out <= raw_to_us(clamp_raw(div_q), base_r);
      end
      // auto value is kept in plain microseconds, not base multiples
      if (auto_wr)
        auto_abs_out <= clamp_us(auto_us); // R12
    end
  end

  // ========================================================
  // arming, exposure timing and frame-rate gate
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      trig_d_r <= 1'b0;
      armed <= 1'b0;
      exposing <= 1'b0;
      readout_start <= 1'b0;
      us_left_r <= 24'h000000;
      sub_r <= 7'h00;
      // saturated count: the first edge after reset meets no gate
      per_cnt_r <= `HTEC_PER_SAT;
      trigger_ready_output <= 1'b0;
    end else begin
      trig_d_r <= trig_act;
      readout_start <= 1'b0;
      // the count stops at saturation instead of wrapping
      per_cnt_r <= per_cnt_nxt;
      // stop wins over start in the same cycle
      if (acq_stop)
        armed <= 1'b0; // R05
      else if (acq_start)
        armed <= 1'b1; // R01
      case (state_r)
        S_IDLE: begin
          // R02 R06: source relies on ready; edges while not ready drop, save in the first idle clock after arming or readout
          if (armed && !acq_stop && trig_edge && rate_ok) begin // R01 R05
            state_r <= S_EXP;
            exposing <= 1'b1;
            per_cnt_r <= 32'h00000001;
            us_left_r <= exp_used;
            sub_r <= `HTEC_US_CYC - 7'h01;
          end
        end
        S_EXP: begin
          // count microseconds for the programmed time exactly
          if (sub_r != 7'h00)
            sub_r <= sub_r - 7'h01;
          else begin
            sub_r <= `HTEC_US_CYC - 7'h01;
            if (us_left_r != 24'h000000)
              us_left_r <= us_left_r - 24'h000001;
          end
          // width mode ends on the first inactive sample, no stretch
          if ((!width_mode && us_left_r == 24'h000001 &&
               sub_r == 7'h00) ||
              (width_mode && !trig_act)) begin // R03 R15
            state_r <= S_RD;
            exposing <= 1'b0;
            readout_start <= 1'b1; // R04
          end
        end
        S_RD: begin
          // readout side owns the sensor until done; edges here drop
          if (readout_done)
            state_r <= S_IDLE; // R04
        end
        // an illegal code falls back to idle
        default: state_r <= S_IDLE;
      endcase
      // ready only when idle, armed, and the rate gate is open
      trigger_ready_output <= armed && !acq_stop && (state_r == S_IDLE) &&
                              !(trig_edge && rate_ok) &&
                              period_met(per_cnt_nxt, eff_period); // R17
    end
  end
endmodule

// *** dv/htec_chk.sv ***
`timescale 1ns/1ps
// ==========================================================
// port checks on the trigger exposure controller
module htec_chk (
  // clock and reset
  input wire        mclk,
  input wire        sys_rst,
  // commands and modes
  input wire        acq_stop,
  input wire        edge_falling,
  input wire        width_mode,
  // pins and status
  input wire        external_trigger_input,
  input wire        trigger_ready_output,
  input wire        armed,
  input wire        exposing,
  input wire        readout_start,
  input wire [23:0] exp_abs_out,
  input wire        auto_active
);
  reg [31:0] cnt_r;
  // ==========================================================
  // length of the running exposure, cleared between exposures
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)
      cnt_r <= 32'h0;
    else
      cnt_r <= exposing ? cnt_r + 32'h1 : 32'h0;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // an edge the block must take
  sequence take_s;
    armed && trigger_ready_output && !acq_stop && !edge_falling
      && $rose(external_trigger_input);
  endsequence
  // end of a timed exposure
  sequence end_s;
    $fell(exposing) && !width_mode;
  endsequence
  ready_low_a: assert property (exposing |-> !trigger_ready_output)
    else $error("trigger ready high while exposing");
  rdy_first_a: assert property (
    $rose(exposing) |-> $past(trigger_ready_output))
    else $error("exposure began while not ready");
  take_edge_a: assert property (take_s |=> exposing)
    else $error("qualifying trigger edge not taken");
  readout_a: assert property (end_s |-> readout_start)
    else $error("no readout start at exposure end");
  exp_len_a: assert property (
    (end_s and !auto_active) |-> cnt_r == exp_abs_out * 32'd100)
    else $error("timed exposure length wrong");
  width_end_a: assert property (
    width_mode && exposing && external_trigger_input == edge_falling
      |=> !exposing)
    else $error("width exposure outlived the trigger");
  auto_off_a: assert property (width_mode |=> !auto_active)
    else $error("auto exposure active in width mode");
  stop_quiet_a: assert property (
    acq_stop && !exposing |=> (!armed && !exposing) [*8])
    else $error("activity after stop");
endmodule
bind htec_ctrl htec_chk chk_i (
  .mclk(mclk), .sys_rst(sys_rst), .acq_stop(acq_stop),
  .edge_falling(edge_falling), .width_mode(width_mode),
  .external_trigger_input(external_trigger_input),
  .trigger_ready_output(trigger_ready_output), .armed(armed),
  .exposing(exposing), .readout_start(readout_start),
  .exp_abs_out(exp_abs_out), .auto_active(auto_active)
);

// *** dv/htec_src.sv ***
`timescale 1ns/1ps
// ==========================================================
// trigger source and readout side of the controller
module htec_src (
  // bench control
  input wire       mclk,
  input wire       fire,
  input wire       rude,
  input wire [7:0] hi_cyc,
  // controller side
  input wire       trigger_ready_output,
  input wire       readout_start,
  output reg       external_trigger_input,
  output reg       readout_done
);
  initial begin
    external_trigger_input = 1'b0;
    readout_done = 1'b0;
  end
  // waits for ready unless told to misbehave, which tests the gate
  always begin
    @(negedge mclk);
    if (fire && (rude || trigger_ready_output)) begin
      external_trigger_input = 1'b1;
      repeat (hi_cyc) @(negedge mclk);
      external_trigger_input = 1'b0;
    end
  end
  // readout ends after a random stall, so ready timing varies
  always begin
    @(negedge mclk);
    if (readout_start) begin
      repeat ($urandom_range(20, 1)) @(negedge mclk);
      readout_done = 1'b1;
      @(negedge mclk);
      readout_done = 1'b0;
    end
  end
endmodule

// *** dv/htec_ctrl_bench.sv ***
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the trigger exposure controller
module htec_ctrl_bench;
  reg        mclk = 1'b0;
  reg        sys_rst, acq_start, acq_stop, width_mode, auto_en, rate_en;
  reg        fire, rude;
  reg [3:0]  wsel;
  reg [7:0]  hi_cyc;
  reg [23:0] val;
  reg [31:0] n, seed, exp_v;
  reg [31:0] expq[$];
  wire       trig, rdy, rd_done, armed, exposing, rd_start, auto_active;
  wire [11:0] raw_out;
  wire [23:0] exp_abs_out, auto_abs_out;
  integer    bad_count = 0, samples_checked = 0, len = 0, gap = 0;
  always #5 mclk = ~mclk;
  htec_ctrl dut (.mclk(mclk), .sys_rst(sys_rst), .acq_start(acq_start),
    .acq_stop(acq_stop), .edge_falling(1'b0), .width_mode(width_mode),
    .raw_wr(wsel[0]), .raw_val(val[11:0]), .abs_wr(wsel[1]),
    .abs_us(val), .base_wr(wsel[2]), .base_us(val), .auto_en(auto_en),
    .auto_wr(wsel[3]), .auto_us(val), .rate_en(rate_en),
    .rate_period_cyc(32'd8000), .min_period_cyc(32'd100),
    .readout_done(rd_done), .external_trigger_input(trig),
    .trigger_ready_output(rdy), .armed(armed), .exposing(exposing),
    .readout_start(rd_start), .raw_out(raw_out),
    .exp_abs_out(exp_abs_out), .auto_abs_out(auto_abs_out),
    .auto_active(auto_active));
  htec_src src (.mclk(mclk), .fire(fire), .rude(rude), .hi_cyc(hi_cyc),
    .trigger_ready_output(rdy), .readout_start(rd_start),
    .external_trigger_input(trig), .readout_done(rd_done));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // one setting write, then time for rounding to settle
  task wr(input [1:0] k, input [23:0] v);
    begin
      @(negedge mclk);
      val = v;
      wsel = 4'h1 << k;
      @(negedge mclk);
      wsel = 4'h0;
      repeat (40) @(negedge mclk);
    end
  endtask
  task go(input s);
    begin
      @(negedge mclk);
      acq_start = s;
      acq_stop = !s;
      @(negedge mclk);
      acq_start = 1'b0;
      acq_stop = 1'b0;
    end
  endtask
  // note k exposures of length e, let the source trigger until done
  task run(input integer k, input [31:0] e);
    integer i;
    begin
      repeat (k) expq.push_back(e);
      fire = 1'b1;
      for (i = 0; i < 40000 && expq.size() > 0; i = i + 1)
        @(negedge mclk);
      fire = 1'b0;
      chk(expq.size(), 32'h0);
    end
  endtask
  task report_and_stop;
    begin
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // measures each exposure and the spacing of starts
  always @(negedge mclk) begin
    gap = gap + 1;
    if (exposing === 1'b1) begin
      if (len == 0 && rate_en) chk(gap >= 8000, 32'h1);
      if (len == 0) gap = 0;
      len = len + 1;
    end else if (len > 0) begin
      exp_v = expq.size() > 0 ? expq.pop_front() : 32'hffffffff;
      chk(len, exp_v);
      len = 0;
    end
  end
  initial begin
    #900000;
    bad_count = bad_count + 1;
    report_and_stop;
  end
  initial begin
    {acq_start, acq_stop, width_mode, auto_en, rate_en, fire, rude} = 7'h0;
    wsel = 4'h0;
    val = 24'h0;
    hi_cyc = 8'h04;
    sys_rst = 1'b1;
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    seed = $urandom(32'hb66d0e51);
    chk(raw_out, 32'hfff);
    chk(exp_abs_out, 32'h13fec);
    chk(auto_abs_out, 32'h3e8);
    wr(2, 24'h1);
    wr(0, 24'h0);
    chk(raw_out, 32'h1);
    wr(0, 24'h5);
    chk(exp_abs_out, 32'h18);
    wr(2, 24'ha);
    wr(1, 24'h2e);
    chk(raw_out, 32'h5);
    chk(exp_abs_out, 32'h32);
    wr(2, 24'h0f4240);
    wr(0, 24'h2);
    chk(exp_abs_out, 32'h0f4240);
    wr(2, 24'h1);
    n = $urandom_range(40, 24);
    wr(0, n[23:0]);
    go(1'b1);
    run(3, n * 100);
    rate_en = 1'b1;
    run(2, n * 100);
    auto_en = 1'b1;
    wr(3, 24'h25);
    chk(auto_abs_out, 32'h25);
    run(1, 32'd3700);
    // edges after stop must leave no exposure behind
    go(1'b0);
    {rude, fire} = 2'h3;
    repeat (2000) @(negedge mclk);
    {rude, fire} = 2'h0;
    width_mode = 1'b1;
    hi_cyc = 8'd50;
    go(1'b1);
    run(1, 32'd50);
    report_and_stop;
  end
endmodule
